/* hdl/doimg_top.sv */
// Digital output image mapper with per-channel diagnostics.
// Assumes the controller uses the strobe port; field fault sense is
// synchronous to mclk.
//
// Functional notes
// [R1] Any overload, short or broken wire sets that channel's fault flag.
// [R2] Faults go to input image; drive bits come from output image.
// [R3] Two-channel flag variant: bits 0,1 map channels 1,2 both ways.
// [R4] Two-channel coded variant: two-bit code per channel, outputs 2,3 unused.
// [R5] Code 00 normal, 01 open or short to supply, 10 ground/overload.
// [R6] Four-channel plain variant: outputs 0..3 drive channels, no input.
// [R7] Four-channel flag variant: flags bits 0..3, 0 ok, 1 fault.
// [R8] Eight-channel variant: outputs 0..7 drive channels 1..8.
// [R9] Eight-channel flag variant: flags bits 0..7, same encoding.
// [R10] Sixteen-channel variant: 16-bit output word drives all channels.
// [R11] Digital output bytes follow analog output data in the image.
// [R12] Controller also evaluates data bits of a flagged channel.
// [R13] Unused input bits read zero; unused output bits are ignored.
`timescale 1ns/100ps
module doimg_top
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [15:0] rdata,
  // Field side
  input wire doimg_pkg::doimg_fault_t [15:0] fault_sense,
  output logic [15:0] ch_drive,
  output logic [15:0] in_image,
  output logic [7:0] dig_byte_base
);

  // ------------------------------------------------------------------
  // Variant masks
  // ------------------------------------------------------------------
  logic [2:0] var_reg;
  doimg_pkg::doimg_variant_t vsel;
  logic [15:0] out_mask;
  logic [15:0] out_reg;
  logic [15:0] out_next;
  logic [15:0] in_next;
  logic [15:0] flag_vec;
  logic [7:0] abase_reg;

  assign vsel = doimg_pkg::doimg_variant_t'(var_reg);

  // [R13] Output mask
  always_comb
  begin
    case (vsel)
      // [R3] Two channels
      doimg_pkg::DOIMG_V2_FLAG: out_mask = 16'h0003;
      // [R4] Bits 2,3 unused
      doimg_pkg::DOIMG_V2_CODE: out_mask = 16'h0003;
      doimg_pkg::DOIMG_V2_PLAIN: out_mask = 16'h0003;
      // [R6] Four channels
      doimg_pkg::DOIMG_V4_PLAIN: out_mask = 16'h000f;
      doimg_pkg::DOIMG_V4_FLAG: out_mask = 16'h000f;
      // [R8] Eight channels
      doimg_pkg::DOIMG_V8_PLAIN: out_mask = 16'h00ff;
      doimg_pkg::DOIMG_V8_FLAG: out_mask = 16'h00ff;
      // [R10] Full word
      doimg_pkg::DOIMG_V16: out_mask = 16'hffff;
      default: out_mask = 16'h0000;
    endcase
  end

  // ------------------------------------------------------------------
  // Fault detection
  // ------------------------------------------------------------------
  // [R1] Any fault raises flag
  always_comb
  begin
    for (int i = 0; i < doimg_pkg::DOIMG_NCH; i++)
    begin
      flag_vec[i] = fault_sense[i].overload | fault_sense[i].short_gnd |
                    fault_sense[i].short_pos | fault_sense[i].open_load;
    end
  end

  // Coded variant takes ground/overload first: it is the harsher case
  function automatic logic [1:0] fault_code(doimg_pkg::doimg_fault_t f);
    // [R5] Two-bit code
    if (f.overload | f.short_gnd)
      fault_code = doimg_pkg::DOIMG_CODE_GND;
    else if (f.open_load | f.short_pos)
      fault_code = doimg_pkg::DOIMG_CODE_OPEN;
    else
      fault_code = doimg_pkg::DOIMG_CODE_OK;
  endfunction : fault_code

  // [R2] Input image build
  always_comb
  begin
    in_next = 16'h0000;
    case (vsel)
      // [R3] Flags on bits 0,1
      doimg_pkg::DOIMG_V2_FLAG: in_next[1:0] = flag_vec[1:0];
      // [R4] Codes on bits 1:0 and 3:2
      doimg_pkg::DOIMG_V2_CODE:
      begin
        in_next[1:0] = fault_code(fault_sense[0]);
        in_next[3:2] = fault_code(fault_sense[1]);
      end
      // [R7] Four flags
      doimg_pkg::DOIMG_V4_FLAG: in_next[3:0] = flag_vec[3:0];
      // [R9] Eight flags
      doimg_pkg::DOIMG_V8_FLAG: in_next[7:0] = flag_vec[7:0];
      // [R13] No input data elsewhere
      default: in_next = 16'h0000;
    endcase
  end

  // ------------------------------------------------------------------
  // Register port
  // ------------------------------------------------------------------
  // [R13] Unused bits dropped on write
  always_comb
  begin
    out_next = out_reg & out_mask;
    if (wr_stb && addr == doimg_pkg::DOIMG_OFF_OUT)
      out_next = wdata & out_mask;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      out_reg <= doimg_pkg::DOIMG_OUT_RST;
    else
      out_reg <= out_next;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      var_reg <= doimg_pkg::DOIMG_VAR_RST;
    else if (wr_stb && addr == doimg_pkg::DOIMG_OFF_VAR)
      var_reg <= wdata[2:0];
  end

  // [R11] Byte offset after analog data
  always_ff @(posedge mclk)
  begin
    if (rst)
      abase_reg <= doimg_pkg::DOIMG_ABASE_RST;
    else if (wr_stb && addr == doimg_pkg::DOIMG_OFF_ABASE)
      abase_reg <= wdata[7:0];
  end

  // Image and drive outputs, registered
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      in_image <= 16'h0000;
      ch_drive <= 16'h0000;
      dig_byte_base <= 8'h00;
    end
    else
    begin
      // [R2] Drive from output image
      in_image <= in_next;
      ch_drive <= out_next;
      dig_byte_base <= abase_reg;
    end
  end

  // Read data one cycle after strobe; zero otherwise
  always_ff @(posedge mclk)
  begin
    if (rst)
      rdata <= 16'h0000;
    else if (rd_stb)
    begin
      case (addr)
        doimg_pkg::DOIMG_OFF_OUT: rdata <= out_reg;
        doimg_pkg::DOIMG_OFF_IN: rdata <= in_next;
        doimg_pkg::DOIMG_OFF_VAR: rdata <= {13'h0, var_reg};
        doimg_pkg::DOIMG_OFF_ABASE: rdata <= {8'h00, abase_reg};
        default: rdata <= 16'h0000;
      endcase
    end
    else
      rdata <= 16'h0000;
  end

endmodule : doimg_top

/* hdl/doimg_pkg.sv */
// Package for the digital output image block: variants, channel count, reset values,
// fault codes and the port-mapped register offsets.
// Assumes one system clock and a plain strobe register port.
package doimg_pkg;

  // ------------------------------------------------------------------
  // Variants
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    DOIMG_V2_FLAG  = 3'h0,
    DOIMG_V2_CODE  = 3'h1,
    DOIMG_V4_PLAIN = 3'h2,
    DOIMG_V4_FLAG  = 3'h3,
    DOIMG_V8_PLAIN = 3'h4,
    DOIMG_V8_FLAG  = 3'h5,
    DOIMG_V16      = 3'h6,
    DOIMG_V2_PLAIN = 3'h7
  } doimg_variant_t;

  // ------------------------------------------------------------------
  // Sizes and codes
  // ------------------------------------------------------------------
  localparam int DOIMG_NCH = 16;
  localparam logic [1:0] DOIMG_CODE_OK = 2'h0;
  localparam logic [1:0] DOIMG_CODE_OPEN = 2'h1;
  localparam logic [1:0] DOIMG_CODE_GND = 2'h2;
  localparam logic [15:0] DOIMG_OUT_RST = 16'h0000;
  localparam logic [2:0] DOIMG_VAR_RST = 3'h0;
  localparam logic [7:0] DOIMG_ABASE_RST = 8'h00;

  // ------------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------------
  localparam logic [3:0] DOIMG_OFF_OUT = 4'h0;
  localparam logic [3:0] DOIMG_OFF_IN = 4'h1;
  localparam logic [3:0] DOIMG_OFF_VAR = 4'h2;
  localparam logic [3:0] DOIMG_OFF_ABASE = 4'h3;

  // Per-channel fault sense from the driver stage
  typedef struct packed {
    logic overload;
    logic short_gnd;
    logic short_pos;
    logic open_load;
  } doimg_fault_t;

endpackage : doimg_pkg

/* sim/doimg_properties.sv */
// Port checker for doimg_top.
// Bound from tb_top; sees only the top ports.
`timescale 1ns/100ps
module doimg_properties
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [15:0] rdata,
  // Field side
  input wire doimg_pkg::doimg_fault_t [15:0] fault_sense,
  input wire logic [15:0] ch_drive,
  input wire logic [15:0] in_image,
  input wire logic [7:0] dig_byte_base
);
  logic [2:0] v_reg, p_reg;
  logic [1:0] c_reg;
  logic s;
  doimg_pkg::doimg_fault_t f;
  assign f = fault_sense[0];
  // Variant unchanged over the last edge
  assign s = v_reg == p_reg;
  always_ff @(posedge mclk)
  begin
    p_reg <= rst ? 3'h0 : v_reg;
    c_reg <= rst ? 2'h0 : (f.overload | f.short_gnd) ? 2'h2 : {1'b0, |f};
    if (rst) v_reg <= 3'h0;
    else if (wr_stb && addr == 4'h2) v_reg <= wdata[2:0];
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_rdata_idle: assert property (
    !$past(rd_stb) |-> rdata == 16'h0000) else $error("rdata not zero");
  a_narrow_drive: assert property (
    s && v_reg inside {3'h0, 3'h1, 3'h7} |-> ch_drive[15:2] == 14'h0)
    else $error("two channel drive too wide");
  a_four_drive: assert property (
    s && v_reg inside {3'h2, 3'h3} |-> ch_drive[15:4] == 12'h000)
    else $error("four channel drive too wide");
  a_eight_drive: assert property (
    s && v_reg inside {3'h4, 3'h5} |-> ch_drive[15:8] == 8'h00)
    else $error("eight channel drive too wide");
  a_write_drive: assert property (
    $past(wr_stb && addr == 4'h0) && s && v_reg == 3'h6
    |-> ch_drive == $past(wdata)) else $error("word drive wrong");
  a_flag_map: assert property (
    s && v_reg inside {3'h0, 3'h3, 3'h5} |-> in_image[0] == |c_reg)
    else $error("flag wrong");
  a_code_map: assert property (
    s && v_reg == 3'h1 |-> in_image[1:0] == c_reg && in_image[15:4] == 0)
    else $error("code wrong");
  a_plain_noin: assert property (
    s && v_reg inside {3'h2, 3'h4, 3'h6, 3'h7} |-> in_image == 16'h0000)
    else $error("plain variant image set");
  a_base_copy: assert property (
    $past(wr_stb && addr == 4'h3, 2)
    |-> dig_byte_base == $past(wdata[7:0], 2)) else $error("base wrong");
  c_code: cover property (v_reg == 3'h1 && c_reg == 2'h2);
  c_wide: cover property (v_reg == 3'h6 && wr_stb);
  c_read: cover property (rd_stb ##1 rdata != 16'h0000);
endmodule : doimg_properties

/* sim/doimg_ctl_model.sv */
// Controller model: writes output image, reads registers back.
// Assumes read data stand one cycle after the strobe.
`timescale 1ns/100ps
module doimg_ctl_model
(
  // Clock and answer
  input wire logic mclk,
  input wire logic [15:0] rdata,
  // Request
  output logic [3:0] addr,
  output logic [15:0] wdata,
  output logic wr_stb,
  output logic rd_stb
);
  initial
  begin
    addr = 4'h0;
    wdata = 16'h0000;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
  end
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
    wdata <= ~d;
    addr <= ~a;
    #1;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    addr <= ~a;
    #1;
    d = rdata;
  endtask : rd
endmodule : doimg_ctl_model

/* sim/tb_top.sv */
// Self-checking bench for doimg_top.
// Controller model drives the register port; bench drives faults.
`timescale 1ns/100ps
module tb_top;
  logic mclk, rst, wr_stb, rd_stb;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, ch_drive, in_image, rv;
  logic [7:0] dig_byte_base;
  doimg_pkg::doimg_fault_t [15:0] fault_sense;
  int err_count = 0;
  int num_checks = 0;
  localparam logic [15:0] MASK [8] = '{16'h0003, 16'h0003, 16'h000f,
    16'h000f, 16'h00ff, 16'h00ff, 16'hffff, 16'h0003};
  doimg_top doimg_top_i (.mclk(mclk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .fault_sense(fault_sense), .ch_drive(ch_drive),
    .in_image(in_image), .dig_byte_base(dig_byte_base));
  doimg_ctl_model doimg_ctl_model_i (.mclk(mclk), .rdata(rdata),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb));
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic chk(input string n, input logic [15:0] e, g);
    num_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic settle;
    repeat (2) @(posedge mclk);
    #1;
  endtask : settle
  task automatic give_verdict;
    if (err_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  task automatic set_all(input logic [3:0] k, input logic [15:0] m);
    for (int i = 0; i < 16; i++) fault_sense[i] <= m[i] ? k : 4'h0;
  endtask : set_all
  task automatic t_widths;
    logic [15:0] prev;
    prev = 16'h0000;
    for (int v = 0; v < 8; v++)
    begin
      doimg_ctl_model_i.wr(4'h2, 16'(v));
      settle;
      chk("trim", prev & MASK[v], ch_drive);
      doimg_ctl_model_i.wr(4'h0, 16'hc5a9);
      prev = 16'hc5a9 & MASK[v];
      chk("drive", prev, ch_drive);
      doimg_ctl_model_i.rd(4'h0, rv);
      chk("out", prev, rv);
    end
  endtask : t_widths
  task automatic t_flags;
    int vs [3] = '{0, 3, 5};
    for (int j = 0; j < 3; j++)
    begin
      doimg_ctl_model_i.wr(4'h2, 16'(vs[j]));
      for (int k = 0; k < 4; k++)
      begin
        set_all(4'h1 << k, 16'haaaa);
        settle;
        chk("flags", 16'haaaa & MASK[vs[j]], in_image);
      end
      set_all(4'h0, 16'hffff);
      settle;
      chk("clear", 16'h0000, in_image);
    end
  endtask : t_flags
  task automatic t_codes;
    logic [1:0] code [4] = '{2'h1, 2'h1, 2'h2, 2'h2};
    doimg_ctl_model_i.wr(4'h2, 16'h0001);
    for (int k = 0; k < 5; k++)
    begin
      set_all(4'hf, 16'hfffc);
      fault_sense[0] <= (k < 4) ? 4'h1 << k : 4'h9;
      fault_sense[1] <= 4'h2;
      settle;
      chk("code", {12'h001, (k < 4) ? code[k] : 2'h2}, in_image);
      doimg_ctl_model_i.rd(4'h1, rv);
      chk("in read", {12'h001, (k < 4) ? code[k] : 2'h2}, rv);
    end
  endtask : t_codes
  task automatic t_misc;
    doimg_ctl_model_i.wr(4'h2, 16'h0002);
    settle;
    chk("plain", 16'h0000, in_image);
    doimg_ctl_model_i.wr(4'h3, 16'h015a);
    settle;
    chk("base", 16'h005a, {8'h00, dig_byte_base});
    doimg_ctl_model_i.rd(4'h3, rv);
    chk("abase", 16'h005a, rv);
    doimg_ctl_model_i.wr(4'hf, 16'hffff);
    doimg_ctl_model_i.rd(4'hf, rv);
    chk("hole", 16'h0000, rv);
  endtask : t_misc
  initial
  begin
    rst = 1'b1;
    fault_sense = '0;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    #1;
    chk("rst drive", 16'h0000, ch_drive);
    doimg_ctl_model_i.rd(4'h2, rv);
    chk("rst var", 16'h0000, rv);
    t_widths;
    t_flags;
    t_codes;
    t_misc;
    give_verdict;
  end
endmodule : tb_top
bind doimg_top doimg_properties doimg_properties_i (.mclk(mclk), .rst(rst),
  .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
  .rdata(rdata), .fault_sense(fault_sense), .ch_drive(ch_drive),
  .in_image(in_image), .dig_byte_base(dig_byte_base));
